// [ecv_device.sv]
`timescale 1ns/10ps
// Notes on behaviour
// (RULE1) verify opcode carries 64-byte signature R then S
// (RULE2) mac only in external or stored verify modes
// (RULE3) mac needs io protection enabled
// (RULE4) mac only after good signature, uses nonce
// (RULE5) external key selector P256, 128 data bytes
// (RULE6) external mac modes choose message and nonce place
// (RULE7) host preloads 32-byte digest in fixed mode
// (RULE8) digest in temp key: nonce in buffer low
// (RULE9) digest in buffer: load digest and nonce together
// (RULE10) non-mac modes answer one result byte
// (RULE11) mac modes answer 32-byte mac or one byte
// (RULE12) external mac input order ends with parameter
// (RULE13) stored key from slot, only signature sent
// (RULE14) stored modes 0x80 and 0xA0 return mac
// (RULE15) stored mac input follows message location
// (RULE16) host validates stored key before use
// (RULE17) external mode keeps no key state
// (RULE18) mac is sha-256 over ordered fields
// (RULE19) stored mac input ends with parameter too
module ecv_device
    import ecv_pkg::*;
(
    input  wire logic         REF_CLK,
    input  wire logic         RSTN,
    input  wire logic         CE,
    ecv_if.dev                LINK,
    input  wire logic [255:0] TEMP_KEY,
    input  wire logic [511:0] MSG_DIGEST_BUF,
    input  wire logic [255:0] IO_KEY,
    input  wire logic         IO_PROT_EN,
    output logic              ECC_REQ,
    output logic              ECC_EXT,
    output logic      [3:0]   ECC_SLOT,
    output logic      [255:0] ECC_MSG,
    input  wire logic [6:0]   ECC_ADDR,
    output logic      [7:0]   ECC_BYTE,
    input  wire logic         ECC_DONE,
    input  wire logic         ECC_OK,
    input  wire logic         ECC_FAULT,
    output logic              SHA_VALID,
    output logic      [7:0]   SHA_DATA,
    output logic              SHA_LAST,
    input  wire logic         SHA_READY,
    input  wire logic         SHA_DONE,
    input  wire logic [255:0] SHA_DIGEST,
    output logic              BUSY
);
    // ==========================================================
    // storage
    ecv_dev_state_t state;
    logic [7:0]     data_mem [0:DATA_MAX-1];
    logic [7:0]     cnt;
    logic [7:0]     opcode;
    logic [7:0]     mode;
    logic [15:0]    p2;
    logic [255:0]   nonce_q;
    logic [255:0]   mac_q;
    logic [7:0]     code;
    logic           rsp_mac;
    logic [7:0]     idx;
    logic [5:0]     ridx;

    // ==========================================================
    // mode and parameter decode
    wire mode_ext   = (mode == M_EXT_TK) || (mode == M_EXT_BUF) ||
                      (mode == M_EXT_TK_MAC) || (mode == M_EXT_BUF_MAC);
    wire mode_sto   = (mode == M_STO_TK) || (mode == M_STO_BUF) ||
                      (mode == M_STO_TK_MAC) || (mode == M_STO_BUF_MAC);
    wire want_mac   = mode[MODE_MAC_BIT];                       // see RULE14
    wire msg_in_buf = (mode == M_STO_BUF) || (mode == M_STO_BUF_MAC) ||
                      (mode == M_EXT_BUF) || (mode == M_EXT_BUF_MAC);
    // data length: signature only, or signature plus key
    wire [7:0] data_len = mode[MODE_EXT_BIT] ? 8'(DATA_MAX) : 8'(SIG_BYTES); // see RULE5 see RULE13
    wire [7:0] last_cnt = 8'(HDR_BYTES - 1) + data_len;             // see RULE1
    wire       take     = LINK.cmd_valid && LINK.cmd_ready;
    wire       rx_last  = take && (cnt >= 8'(HDR_BYTES)) && (cnt == last_cnt);
    wire       sel_ok   = !mode_ext || (p2 == KEY_SEL_P256);      // see RULE5
    wire       prot_ok  = !want_mac || IO_PROT_EN;                 // see RULE3
    wire       param_ok = (opcode == OPC_VERIFY) && (mode_ext || mode_sto) &&
                          sel_ok && prot_ok;                       // see RULE2
    // message and nonce positions follow where the message lies
    wire [255:0] msg_sel   = msg_in_buf ? MSG_DIGEST_BUF[255:0] : TEMP_KEY;           // see RULE6
    wire [255:0] nonce_sel = msg_in_buf ? MSG_DIGEST_BUF[511:256] : MSG_DIGEST_BUF[255:0]; // see RULE15
    wire [6:0]   sig_addr  = 7'(idx - MAC_OFS_SIG);
    wire [7:0]   mac_byte;
    wire [7:0]   rsp_byte  = rsp_mac ? mac_q[{ridx[4:0], 3'h0} +: 8] : code;
    wire         rsp_end   = !rsp_mac || (ridx == 6'(DIG_BYTES - 1));

    // ==========================================================
    // mac input formatter
    ecv_mac_fmt u_fmt (
        .idx      (idx),
        .io_key   (IO_KEY),
        .msg      (ECC_MSG),
        .nonce    (nonce_q),
        .sig_byte (data_mem[sig_addr]),
        .mode     (mode),
        .p2       (p2),
        .mac_byte (mac_byte)
    );

    // ==========================================================
    // received data bytes and engine read port
    always_ff @(posedge REF_CLK) begin
        if (CE) begin
            if (take && cnt >= 8'(HDR_BYTES))
                data_mem[7'(cnt - 8'(HDR_BYTES))] <= LINK.cmd_data;
        end
    end

    // operand bytes for the curve engine
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN)
            ECC_BYTE <= 8'h00;
        else if (CE)
            ECC_BYTE <= data_mem[ECC_ADDR];
    end

    // ==========================================================
    // command sequencer
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state          <= ST_RX;
            cnt            <= 8'h00;
            opcode         <= 8'h00;
            mode           <= 8'h00;
            p2             <= 16'h0000;
            nonce_q        <= '0;
            mac_q          <= '0;
            code           <= 8'h00;
            rsp_mac        <= 1'b0;
            idx            <= 8'h00;
            ridx           <= 6'h00;
            ECC_REQ        <= 1'b0;
            ECC_EXT        <= 1'b0;
            ECC_SLOT       <= 4'h0;
            ECC_MSG        <= '0;
            SHA_VALID      <= 1'b0;
            SHA_DATA       <= 8'h00;
            SHA_LAST       <= 1'b0;
            BUSY           <= 1'b0;
            LINK.cmd_ready <= 1'b0;
            LINK.rsp_valid <= 1'b0;
            LINK.rsp_data  <= 8'h00;
            LINK.rsp_last  <= 1'b0;
        end else if (CE) begin
            ECC_REQ <= 1'b0;
            case (state)
                ST_RX: begin
                    LINK.cmd_ready <= !rx_last;
                    if (take) begin
                        cnt  <= rx_last ? 8'h00 : cnt + 8'h01;
                        BUSY <= 1'b1;
                        case (cnt)
                            8'h00:   opcode <= LINK.cmd_data;
                            8'h01:   mode <= LINK.cmd_data;
                            8'h02:   p2[7:0] <= LINK.cmd_data;   // low byte first
                            8'h03:   p2[15:8] <= LINK.cmd_data;
                            default: ;
                        endcase
                    end
                    if (rx_last)
                        state <= ST_CHK;
                end
                ST_CHK: begin
                    ECC_MSG <= msg_sel;                       // see RULE7
                    nonce_q <= nonce_sel;                     // see RULE8 see RULE9
                    ECC_EXT <= mode_ext;                      // see RULE17
                    ECC_SLOT <= p2[3:0];                      // see RULE13
                    if (param_ok) begin
                        ECC_REQ <= 1'b1;
                        state   <= ST_ECC;
                    end else begin
                        code    <= ERR_PARAM;
                        rsp_mac <= 1'b0;
                        state   <= ST_RESP;
                    end
                end
                ST_ECC: begin
                    if (ECC_DONE) begin
                        rsp_mac <= 1'b0;
                        idx     <= MAC_OFS_KEY;
                        if (ECC_FAULT) begin
                            code  <= ERR_EXEC;                // see RULE10
                            state <= ST_RESP;
                        end else if (!ECC_OK) begin
                            code  <= RES_MISMATCH;            // see RULE11
                            state <= ST_RESP;
                        end else if (want_mac) begin
                            state <= ST_HASH;                 // see RULE4
                        end else begin
                            code  <= RES_OK;                  // see RULE10
                            state <= ST_RESP;
                        end
                    end
                end
                ST_HASH: begin
                    if (!SHA_VALID) begin
                        SHA_VALID <= 1'b1;
                        SHA_DATA  <= mac_byte;                // see RULE12 see RULE18
                        SHA_LAST  <= (idx == MAC_LAST);       // see RULE19
                    end else if (SHA_READY) begin
                        SHA_VALID <= 1'b0;
                        SHA_LAST  <= 1'b0;
                        idx       <= idx + 8'h01;
                        if (SHA_LAST)
                            state <= ST_HWAIT;
                    end
                end
                ST_HWAIT: begin
                    if (SHA_DONE) begin
                        mac_q   <= SHA_DIGEST;
                        rsp_mac <= 1'b1;                      // see RULE11
                        state   <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    if (!LINK.rsp_valid) begin
                        LINK.rsp_valid <= 1'b1;
                        LINK.rsp_data  <= rsp_byte;
                        LINK.rsp_last  <= rsp_end;
                    end else if (LINK.rsp_ready) begin
                        LINK.rsp_valid <= 1'b0;
                        LINK.rsp_last  <= 1'b0;
                        ridx           <= ridx + 6'h01;
                        if (LINK.rsp_last) begin
                            ridx           <= 6'h00;
                            BUSY           <= 1'b0;
                            LINK.cmd_ready <= 1'b1;
                            state          <= ST_RX;
                        end
                    end
                end
                default: state <= ST_RX;
            endcase
        end
    end
endmodule

// [ecv_pkg.sv]
// ==========================================================
// shared constants for the signature-verify command path
package ecv_pkg;
    // command framing
    localparam logic [7:0]  OPC_VERIFY    = 8'h45;
    localparam logic [15:0] KEY_SEL_P256  = 16'h0004;
    localparam int          HDR_BYTES     = 4;
    localparam int          SIG_BYTES     = 64;
    localparam int          PUB_BYTES     = 64;
    localparam int          DIG_BYTES     = 32;
    localparam int          DATA_MAX      = SIG_BYTES + PUB_BYTES;
    // mode encodings
    localparam logic [7:0]  M_STO_TK      = 8'h00;
    localparam logic [7:0]  M_STO_BUF     = 8'h20;
    localparam logic [7:0]  M_STO_TK_MAC  = 8'h80;
    localparam logic [7:0]  M_STO_BUF_MAC = 8'hA0;
    localparam logic [7:0]  M_EXT_TK      = 8'h02;
    localparam logic [7:0]  M_EXT_BUF     = 8'h22;
    localparam logic [7:0]  M_EXT_TK_MAC  = 8'hA2;
    localparam logic [7:0]  M_EXT_BUF_MAC = 8'h82;
    localparam int          MODE_MAC_BIT  = 7;
    localparam int          MODE_EXT_BIT  = 1;
    // result codes
    localparam logic [7:0]  RES_OK        = 8'h00;
    localparam logic [7:0]  RES_MISMATCH  = 8'h01;
    localparam logic [7:0]  ERR_PARAM     = 8'h03;
    localparam logic [7:0]  ERR_EXEC      = 8'h0F;
    // mac input layout, byte offsets
    localparam logic [7:0]  MAC_OFS_KEY   = 8'h00;
    localparam logic [7:0]  MAC_OFS_MSG   = 8'h20;
    localparam logic [7:0]  MAC_OFS_NONCE = 8'h40;
    localparam logic [7:0]  MAC_OFS_SIG   = 8'h60;
    localparam logic [7:0]  MAC_OFS_OPC   = 8'hA0;
    localparam logic [7:0]  MAC_OFS_MODE  = 8'hA1;
    localparam logic [7:0]  MAC_OFS_P2LO  = 8'hA2;
    localparam logic [7:0]  MAC_OFS_P2HI  = 8'hA3;
    localparam logic [7:0]  MAC_LAST      = 8'hA3;
    // device states
    typedef enum logic [5:0] {
        ST_RX    = 6'h01,
        ST_CHK   = 6'h02,
        ST_ECC   = 6'h04,
        ST_HASH  = 6'h08,
        ST_HWAIT = 6'h10,
        ST_RESP  = 6'h20
    } ecv_dev_state_t;
    // host states
    typedef enum logic [2:0] {
        HS_IDLE = 3'h1,
        HS_SEND = 3'h2,
        HS_RECV = 3'h4
    } ecv_host_state_t;
endpackage

// [ecv_if.sv]
`timescale 1ns/10ps
// ==========================================================
// byte link between host and verify engine
interface ecv_if;
    logic       cmd_valid;
    logic [7:0] cmd_data;
    logic       cmd_ready;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       rsp_last;
    logic       rsp_ready;
    modport dev (
        input  cmd_valid, cmd_data, rsp_ready,
        output cmd_ready, rsp_valid, rsp_data, rsp_last
    );
    modport host (
        output cmd_valid, cmd_data, rsp_ready,
        input  cmd_ready, rsp_valid, rsp_data, rsp_last
    );
endinterface

// [ecv_mac_fmt.sv]
`timescale 1ns/10ps
// ==========================================================
// selects one byte of the validation mac input by index
module ecv_mac_fmt
    import ecv_pkg::*;
(
    input  wire logic [7:0]   idx,
    input  wire logic [255:0] io_key,
    input  wire logic [255:0] msg,
    input  wire logic [255:0] nonce,
    input  wire logic [7:0]   sig_byte,
    input  wire logic [7:0]   mode,
    input  wire logic [15:0]  p2,
    output logic      [7:0]   mac_byte
);
    wire [4:0] sub = idx[4:0];
    wire [7:0] key_b   = io_key[{sub, 3'h0} +: 8];
    wire [7:0] msg_b   = msg[{sub, 3'h0} +: 8];
    wire [7:0] nonce_b = nonce[{sub, 3'h0} +: 8];

    // key, message, nonce, r, s, opcode, mode, param low then high
    assign mac_byte = (idx < MAC_OFS_MSG)   ? key_b   :
                      (idx < MAC_OFS_NONCE) ? msg_b   :
                      (idx < MAC_OFS_SIG)   ? nonce_b :
                      (idx < MAC_OFS_OPC)   ? sig_byte :
                      (idx == MAC_OFS_OPC)  ? OPC_VERIFY :
                      (idx == MAC_OFS_MODE) ? mode :
                      (idx == MAC_OFS_P2LO) ? p2[7:0] : p2[15:8];
endmodule

// [ecv_host.sv]
`timescale 1ns/10ps
// ==========================================================
// host end: frames a verify request and collects the answer
module ecv_host
    import ecv_pkg::*;
(
    input  wire logic         REF_CLK,
    input  wire logic         RSTN,
    input  wire logic         CE,
    ecv_if.host               LINK,
    input  wire logic         START,
    input  wire logic [7:0]   MODE,
    input  wire logic [15:0]  KEY_SEL,
    input  wire logic [511:0] SIG,
    input  wire logic [511:0] PUB,
    output logic              BUSY,
    output logic              DONE,
    output logic      [7:0]   RESULT,
    output logic      [255:0] MAC,
    output logic              MAC_VALID
);
    ecv_host_state_t state;
    logic [7:0]      idx;
    logic [5:0]      ridx;
    logic [7:0]      mode_q;
    logic [15:0]     sel_q;

    // ==========================================================
    // byte selection for the outgoing frame
    wire [7:0] data_len = mode_q[MODE_EXT_BIT] ? 8'(DATA_MAX) : 8'(SIG_BYTES); // see RULE5 see RULE13
    wire [7:0] last_idx = 8'(HDR_BYTES - 1) + data_len;
    wire [7:0] d        = idx - 8'(HDR_BYTES);
    wire [5:0] d6       = d[5:0];
    wire [7:0] sig_b    = SIG[{d6, 3'h0} +: 8];                // see RULE1
    wire [7:0] pub_b    = PUB[{d6, 3'h0} +: 8];
    wire [7:0] tx_byte  = (idx == 8'h00) ? OPC_VERIFY :
                          (idx == 8'h01) ? mode_q :
                          (idx == 8'h02) ? sel_q[7:0] :
                          (idx == 8'h03) ? sel_q[15:8] :
                          (d < 8'(SIG_BYTES)) ? sig_b : pub_b;
    wire       rsp_take = LINK.rsp_valid && LINK.rsp_ready;

    // ==========================================================
    // request sender and response collector
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state          <= HS_IDLE;
            idx            <= 8'h00;
            ridx           <= 6'h00;
            mode_q         <= 8'h00;
            sel_q          <= 16'h0000;
            BUSY           <= 1'b0;
            DONE           <= 1'b0;
            RESULT         <= 8'h00;
            MAC            <= '0;
            MAC_VALID      <= 1'b0;
            LINK.cmd_valid <= 1'b0;
            LINK.cmd_data  <= 8'h00;
            LINK.rsp_ready <= 1'b0;
        end else if (CE) begin
            DONE           <= 1'b0;
            LINK.rsp_ready <= 1'b1;
            case (state)
                HS_IDLE: begin
                    if (START) begin
                        mode_q <= MODE;
                        sel_q  <= KEY_SEL;
                        idx    <= 8'h00;
                        ridx   <= 6'h00;
                        BUSY   <= 1'b1;
                        state  <= HS_SEND;
                    end
                end
                HS_SEND: begin
                    if (!LINK.cmd_valid) begin
                        LINK.cmd_valid <= 1'b1;
                        LINK.cmd_data  <= tx_byte;
                    end else if (LINK.cmd_ready) begin
                        LINK.cmd_valid <= 1'b0;
                        idx            <= idx + 8'h01;
                        if (idx == last_idx)
                            state <= HS_RECV;
                    end
                end
                HS_RECV: begin
                    if (rsp_take) begin
                        ridx <= ridx + 6'h01;
                        if (ridx == 6'h00)
                            RESULT <= LINK.rsp_data;          // see RULE10
                        MAC[{ridx[4:0], 3'h0} +: 8] <= LINK.rsp_data; // see RULE11
                        if (LINK.rsp_last) begin
                            MAC_VALID <= (ridx == 6'(DIG_BYTES - 1));
                            DONE      <= 1'b1;
                            BUSY      <= 1'b0;
                            state     <= HS_IDLE;
                        end
                    end
                end
                default: state <= HS_IDLE;
            endcase
        end
    end
endmodule

// [ecv_link_checker.sv]
`timescale 1ns/10ps
// ==========================================================
// link checker: framing, spacing and response shape
module ecv_link_checker (
    input wire logic       REF_CLK,
    input wire logic       RSTN,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_data,
    input wire logic       cmd_ready,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic       rsp_last,
    input wire logic       rsp_ready
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    logic [7:0] cnt;
    logic [7:0] rcnt;
    logic [7:0] mode;
    // take strobes and command length by mode
    wire        cmd_take = cmd_valid && cmd_ready;
    wire        rsp_take = rsp_valid && rsp_ready;
    wire  [7:0] total    = mode[1] ? 8'h84 : 8'h44;
    // byte counts of command and response
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt  <= 8'h00;
            rcnt <= 8'h00;
            mode <= 8'h00;
        end else begin
            if (rsp_take && rsp_last)
                cnt <= 8'h00;
            else if (cmd_take)
                cnt <= cnt + 8'h01;
            if (rsp_take)
                rcnt <= rsp_last ? 8'h00 : rcnt + 8'h01;
            if (cmd_take && cnt == 8'h01)
                mode <= cmd_data;
        end
    end
    a_opcode_first: assert property (cmd_valid && cnt == 8'h00 |-> cmd_data == 8'h45)
        else $error("first byte not verify opcode");
    a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
        else $error("byte changed untaken");
    a_cmd_gap: assert property (cmd_take |=> !cmd_valid)
        else $error("no gap after command byte");
    a_cmd_length: assert property (cnt > 8'h03 |-> cnt <= total)
        else $error("command too long");
    a_refuse_after: assert property (cnt == total |-> !cmd_ready)
        else $error("ready after last byte");
    a_rsp_after_cmd: assert property (rsp_valid |-> cnt == total)
        else $error("response too early");
    a_code_single: assert property (rsp_valid && !mode[7] |-> rsp_last)
        else $error("long answer without mac");
    a_mac_modes: assert property (rsp_valid && rcnt > 8'h00 |-> mode[7])
        else $error("mac bytes in non-mac mode");
    a_mac_length: assert property (rsp_valid && rsp_last |-> rcnt == 8'h00 || rcnt == 8'h1F)
        else $error("answer not 1 or 32 bytes");
    a_mac_nonzero: assert property (rsp_valid && mode[7] && rsp_last && rcnt == 8'h00 |-> rsp_data != 8'h00)
        else $error("success code in mac mode");
    a_rsp_gap: assert property (rsp_take |=> !rsp_valid)
        else $error("no gap after response byte");
    c_mac_answer: cover property (rsp_take && rsp_last && rcnt == 8'h1F);
    c_code_answer: cover property (rsp_take && rsp_last && mode[7] && rcnt == 8'h00);
    c_long_cmd: cover property (cmd_take && cnt == 8'h83);
endmodule

// [ecv_tb.sv]
`timescale 1ns/10ps
// ==========================================================
// bench: host and device joined, engines modelled here
module ecv_tb;
    import ecv_pkg::*;
    logic         ref_clk = 1'b0, rstn = 1'b0, start = 1'b0, io_prot_en = 1'b1;
    logic         ecc_done = 1'b0, ecc_ok = 1'b0, ecc_fault = 1'b0, sha_ready = 1'b0, sha_done = 1'b0;
    logic [7:0]   mode = 8'h00;
    logic [15:0]  key_sel = 16'h0000;
    logic [6:0]   ecc_addr = 7'h00;
    logic [511:0] sig, pub, dbuf;
    logic [255:0] tkey, io_key, digest;
    logic [7:0]   cmd_q [0:4095], sha_q [0:4095];
    logic [7:0]   modes [8] = '{M_STO_TK, M_STO_BUF, M_STO_TK_MAC, M_STO_BUF_MAC,
                                M_EXT_TK, M_EXT_BUF, M_EXT_TK_MAC, M_EXT_BUF_MAC};
    int           cmd_n = 0, sha_n = 0, cyc = 0, err_count = 0, num_checks = 0;
    wire          ecc_req, ecc_ext, sha_valid, sha_last, h_busy, d_busy, done, mac_valid;
    wire [3:0]    ecc_slot;
    wire [7:0]    ecc_byte, sha_data, result;
    wire [255:0]  ecc_msg, mac;
    ecv_if ecv_if_i ();
    ecv_device ecv_device_i (.REF_CLK(ref_clk), .RSTN(rstn), .CE(1'b1), .LINK(ecv_if_i), .TEMP_KEY(tkey),
        .MSG_DIGEST_BUF(dbuf), .IO_KEY(io_key), .IO_PROT_EN(io_prot_en), .ECC_REQ(ecc_req), .ECC_EXT(ecc_ext),
        .ECC_SLOT(ecc_slot), .ECC_MSG(ecc_msg), .ECC_ADDR(ecc_addr), .ECC_BYTE(ecc_byte), .ECC_DONE(ecc_done),
        .ECC_OK(ecc_ok), .ECC_FAULT(ecc_fault), .SHA_VALID(sha_valid), .SHA_DATA(sha_data), .SHA_LAST(sha_last),
        .SHA_READY(sha_ready), .SHA_DONE(sha_done), .SHA_DIGEST(digest), .BUSY(d_busy));
    ecv_host ecv_host_i (.REF_CLK(ref_clk), .RSTN(rstn), .CE(1'b1), .LINK(ecv_if_i), .START(start),
        .MODE(mode), .KEY_SEL(key_sel), .SIG(sig), .PUB(pub), .BUSY(h_busy), .DONE(done), .RESULT(result),
        .MAC(mac), .MAC_VALID(mac_valid));
    ecv_link_checker ecv_link_checker_i (.REF_CLK(ref_clk), .RSTN(rstn), .cmd_valid(ecv_if_i.cmd_valid),
        .cmd_data(ecv_if_i.cmd_data), .cmd_ready(ecv_if_i.cmd_ready), .rsp_valid(ecv_if_i.rsp_valid),
        .rsp_data(ecv_if_i.rsp_data), .rsp_last(ecv_if_i.rsp_last), .rsp_ready(ecv_if_i.rsp_ready));
    // clock
    always #5 ref_clk = ~ref_clk;
    // logs link and hash bytes, paces hash input, timeout
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        sha_ready <= cyc[0];
        if (ecv_if_i.cmd_valid && ecv_if_i.cmd_ready) begin
            cmd_q[cmd_n] <= ecv_if_i.cmd_data;
            cmd_n <= cmd_n + 1;
        end
        if (sha_valid && sha_ready) begin
            sha_q[sha_n] <= sha_data;
            sha_n <= sha_n + 1;
        end
        if (cyc == 40000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // expected mac input byte i
    function automatic logic [7:0] mac_in(input int i, input logic [7:0] m, input logic [15:0] k);
        logic bm;
        bm = m inside {M_STO_BUF, M_STO_BUF_MAC, M_EXT_BUF, M_EXT_BUF_MAC};
        if (i < 32) return io_key[i*8 +: 8];
        if (i < 64) return bm ? dbuf[(i-32)*8 +: 8] : tkey[(i-32)*8 +: 8];
        if (i < 96) return bm ? dbuf[(i-32)*8 +: 8] : dbuf[(i-64)*8 +: 8];
        if (i < 160) return sig[(i-96)*8 +: 8];
        return cmd_exp(i - 160, m, k);
    endfunction
    // expected command byte i
    function automatic logic [7:0] cmd_exp(input int i, input logic [7:0] m, input logic [15:0] k);
        if (i < 4) return (i == 0) ? OPC_VERIFY : (i == 1) ? m : (i == 2) ? k[7:0] : k[15:8];
        return (i < 68) ? sig[(i-4)*8 +: 8] : pub[(i-68)*8 +: 8];
    endfunction
    // one verify request, engine answers and checks
    task automatic run(input logic [7:0] m, input logic [15:0] k, input logic ok, input logic flt,
                       input logic [7:0] exp, input logic mc);
        int cb, sb, len, n;
        logic [255:0] em;
        cb = cmd_n;
        sb = sha_n;
        len = m[1] ? 132 : 68;
        for (int i = 0; i < 32; i++) em[i*8 +: 8] = mac_in(32 + i, m, k);
        @(posedge ref_clk);
        mode <= m;
        key_sel <= k;
        start <= 1'b1;
        repeat (2) @(posedge ref_clk);
        start <= 1'b0;
        if (exp !== ERR_PARAM) begin
            n = 0;
            while (ecc_req !== 1'b1 && n < 600) begin @(negedge ref_clk); n++; end
            chk(ecc_req, 1'b1);
            chk({h_busy, d_busy}, 2'b11);
            chk(ecc_ext, m[1]);
            chk(ecc_msg, em);
            if (!m[1]) chk(ecc_slot, k[3:0]);
            @(posedge ref_clk);
            ecc_addr <= 7'h05;
            @(posedge ref_clk);
            ecc_addr <= 7'h46;
            @(negedge ref_clk);
            chk(ecc_byte, sig[47:40]);
            @(negedge ref_clk);
            if (m[1]) chk(ecc_byte, pub[55:48]);
            @(posedge ref_clk);
            ecc_done <= 1'b1;
            ecc_ok <= ok;
            ecc_fault <= flt;
            @(posedge ref_clk);
            ecc_done <= 1'b0;
            if (mc) begin
                n = 0;
                while (!(sha_valid && sha_last && sha_ready) && n < 1500) begin @(negedge ref_clk); n++; end
                repeat (2) @(posedge ref_clk);
                sha_done <= 1'b1;
                @(posedge ref_clk);
                sha_done <= 1'b0;
            end
        end
        n = 0;
        while (done !== 1'b1 && n < 1500) begin @(negedge ref_clk); n++; end
        chk(done, 1'b1);
        chk(result, mc ? digest[7:0] : exp);
        chk(mac_valid, mc);
        if (mc) chk(mac, digest);
        chk(cmd_n - cb, len);
        for (int i = 0; i < len; i++) chk(cmd_q[cb + i], cmd_exp(i, m, k));
        chk(sha_n - sb, mc ? 164 : 0);
        if (mc) for (int i = 0; i < 164; i++) chk(sha_q[sb + i], mac_in(i, m, k));
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        for (int i = 0; i < 64; i++) begin
            sig[i*8 +: 8] = 8'(i);
            pub[i*8 +: 8] = 8'hC0 ^ 8'(i);
            dbuf[i*8 +: 8] = 8'h40 + 8'(i);
        end
        for (int i = 0; i < 32; i++) begin
            tkey[i*8 +: 8] = 8'hE0 ^ 8'(i);
            io_key[i*8 +: 8] = 8'hA5 ^ 8'(i);
            digest[i*8 +: 8] = 8'h3C ^ 8'(i);
        end
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        foreach (modes[i]) run(modes[i], modes[i][1] ? KEY_SEL_P256 : 16'h0003, 1'b1, 1'b0, RES_OK, modes[i][7]);
        run(M_EXT_TK_MAC, KEY_SEL_P256, 1'b0, 1'b0, RES_MISMATCH, 1'b0);
        run(M_STO_TK, 16'h0002, 1'b0, 1'b0, RES_MISMATCH, 1'b0);
        run(M_STO_BUF_MAC, 16'h0001, 1'b1, 1'b1, ERR_EXEC, 1'b0);
        run(M_EXT_BUF, 16'h0005, 1'b1, 1'b0, ERR_PARAM, 1'b0);
        run(8'h03, 16'h0001, 1'b1, 1'b0, ERR_PARAM, 1'b0);
        @(posedge ref_clk);
        io_prot_en <= 1'b0;
        run(M_STO_TK_MAC, 16'h0001, 1'b1, 1'b0, ERR_PARAM, 1'b0);
        print_verdict();
    end
endmodule
